// ==== core/chan_pwr_pkg.sv ====
// Constants and types for the channel power and status register bank
package chan_pwr_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CH_NUM = 8;

  localparam logic [ADDR_W-1:0] PAGE_MAIN = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_IN_CH_ENABLE = 8'h73;
  localparam logic [ADDR_W-1:0] ADDR_POWER_CONFIGURATION = 8'h75;
  localparam logic [ADDR_W-1:0] ADDR_CHANNEL_POWER_STATE = 8'h76;
  localparam logic [ADDR_W-1:0] ADDR_DEVICE_MODE_STATE = 8'h77;
  localparam logic [ADDR_W-1:0] ADDR_CHECKSUM = 8'h7E;

  localparam logic [DATA_W-1:0] RST_IN_CH_ENABLE = 8'hF0;
  localparam logic [DATA_W-1:0] RST_POWER_CONFIGURATION = 8'h00;
  localparam logic [DATA_W-1:0] RST_CHANNEL_POWER_STATE = 8'h00;
  localparam logic [DATA_W-1:0] RST_DEVICE_MODE_STATE = 8'h80;
  localparam logic [DATA_W-1:0] RST_CHECKSUM = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

  // Power configuration field positions
  localparam int CFG_CONVERTER_BIT = 6;
  localparam int CFG_DYNAMIC_BIT = 4;
  localparam int CFG_RANGE_HI = 3;
  localparam int CFG_RANGE_LO = 2;

  // Device mode field
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 5;
  localparam logic [2:0] MODE_SLEEP = 3'h4;
  localparam logic [2:0] MODE_ACTIVE_OFF = 3'h6;
  localparam logic [2:0] MODE_ACTIVE_ON = 3'h7;
  localparam logic [4:0] MODE_RESERVED = 5'h00;

  // Dynamic range masks, channel 1 at bit 7
  localparam logic [CH_NUM-1:0] RANGE_CH1_2 = 8'hC0;
  localparam logic [CH_NUM-1:0] RANGE_CH1_4 = 8'hF0;
  localparam logic [CH_NUM-1:0] RANGE_CH1_6 = 8'hFC;
  localparam logic [CH_NUM-1:0] RANGE_CH1_8 = 8'hFF;
  localparam logic [CH_NUM-1:0] CH_NONE = 8'h00;

  // Power sequencing settle time
  localparam int CLK_PERIOD_NS = 10;
  localparam int POWER_SETTLE_NS = 200;
  localparam int POWER_SETTLE_CYC_I = (POWER_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] POWER_SETTLE_CYC = POWER_SETTLE_CYC_I[7:0];
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] CNT_ONE = 8'h01;

  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_RAMP = 1'b1
  } seq_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] page;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } reg_access_t;
endpackage

// ==== core/channel_power_status_regs.sv ====
// Channel power control, power status and checksum register bank
`timescale 1ns/1ns

// How it works
// - With dynamic control off, converter on and no sleep, the channel set cannot change while any channel is powered.
// - With dynamic control on, channels in range follow their enables while others keep running.
// - The range field selects channels 1-2, 1-4, 1-6 or 1-8 for dynamic control.
// - The channel state register holds one read-only bit per channel, channel 1 at bit 7.
// - Bits for channels 5 to 8 report the digital microphone channels only.
// - The channel state register sits at 0x76 and resets to zero, all channels down.
// - The mode field in bits 7-5 reads 4 in sleep or software shutdown.
// - The mode field reads 6 when active with every channel off.
// - The mode field reads 7 when active with at least one channel on.
// - The mode register sits at 0x77, resets to 80h and reads zero in its low five bits.
// - A readable checksum of control writes sits at 0x7E.
// - The converter power bit powers up all enabled channels when 1 and no channel is on yet, and all down when 0.
// - A channel is powered up only if its input enable is set; clearing the enable alone powers it down only when in range with dynamic control on.
// - Writing the checksum loads it, and every write elsewhere on any page updates it.
module channel_power_status_regs
  import chan_pwr_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire reg_access_t access_in,
  input wire logic sleep_in,
  output logic [DATA_W-1:0] rd_data_out,
  output logic [CH_NUM-1:0] channel_power_out
);

  function automatic logic [CH_NUM-1:0] range_mask(input logic [1:0] sel);
    logic [CH_NUM-1:0] m;
    m = RANGE_CH1_8;
    unique case (sel)
      2'h0: m = RANGE_CH1_2;
      2'h1: m = RANGE_CH1_4;
      2'h2: m = RANGE_CH1_6;
      2'h3: m = RANGE_CH1_8;
    endcase
    return m;
  endfunction

  function automatic logic is_main_addr(input reg_access_t a, input logic [ADDR_W-1:0] ad);
    return (a.page == PAGE_MAIN) && (a.addr == ad);
  endfunction

  // Register file state
  logic [DATA_W-1:0] in_ch_enable_r, in_ch_enable_nxt;
  logic [DATA_W-1:0] power_configuration_r, power_configuration_nxt;
  logic [DATA_W-1:0] checksum_r, checksum_nxt;
  logic [DATA_W-1:0] rd_data_r, rd_data_nxt;
  logic [2:0] mode_r, mode_nxt;

  // Power sequencing state
  logic [CH_NUM-1:0] target_r, target_nxt;
  logic [CH_NUM-1:0] chan_state_r, chan_state_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  seq_state_t seq_r, seq_nxt;

  logic converter_power_control;
  logic dynamic_channel_power_enable;
  logic [1:0] dynamic_channel_range_select;
  logic [CH_NUM-1:0] request;
  logic [CH_NUM-1:0] dyn_mask;
  logic any_on;

  assign converter_power_control = power_configuration_r[CFG_CONVERTER_BIT];
  assign dynamic_channel_power_enable = power_configuration_r[CFG_DYNAMIC_BIT];
  assign dynamic_channel_range_select = power_configuration_r[CFG_RANGE_HI:CFG_RANGE_LO];
  assign dyn_mask = range_mask(dynamic_channel_range_select);
  assign request = converter_power_control ? in_ch_enable_r : CH_NONE;
  assign any_on = |chan_state_r;

  // Register writes, checksum and read data
  always_comb begin
    in_ch_enable_nxt = in_ch_enable_r;
    power_configuration_nxt = power_configuration_r;
    checksum_nxt = checksum_r;
    rd_data_nxt = rd_data_r;
    if (wr_en_in) begin
      if (is_main_addr(access_in, ADDR_CHECKSUM)) begin
        checksum_nxt = access_in.data;
      end else begin
        checksum_nxt = DATA_W'(checksum_r + access_in.addr + access_in.data);
      end
      if (is_main_addr(access_in, ADDR_IN_CH_ENABLE)) begin
        in_ch_enable_nxt = access_in.data;
      end
      if (is_main_addr(access_in, ADDR_POWER_CONFIGURATION)) begin
        power_configuration_nxt = access_in.data;
      end
    end
    if (rd_en_in) begin
      rd_data_nxt = DATA_ZERO;
      if (access_in.page == PAGE_MAIN) begin
        unique case (access_in.addr)
          ADDR_IN_CH_ENABLE: rd_data_nxt = in_ch_enable_r;
          ADDR_POWER_CONFIGURATION: rd_data_nxt = power_configuration_r;
          ADDR_CHANNEL_POWER_STATE: rd_data_nxt = chan_state_r;
          ADDR_DEVICE_MODE_STATE: rd_data_nxt = {mode_r, MODE_RESERVED};
          ADDR_CHECKSUM: rd_data_nxt = checksum_r;
          default: rd_data_nxt = DATA_ZERO;
        endcase
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      in_ch_enable_r <= RST_IN_CH_ENABLE;
      power_configuration_r <= RST_POWER_CONFIGURATION;
      checksum_r <= RST_CHECKSUM;
      rd_data_r <= DATA_ZERO;
    end else if (ce_in) begin
      in_ch_enable_r <= in_ch_enable_nxt;
      power_configuration_r <= power_configuration_nxt;
      checksum_r <= checksum_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  // Target channel set
  always_comb begin
    target_nxt = target_r;
    if (sleep_in || !converter_power_control) begin
      target_nxt = CH_NONE;
    end else if (!any_on) begin
      target_nxt = request;
    end else if (dynamic_channel_power_enable) begin
      target_nxt = (request & dyn_mask) | (target_r & ~dyn_mask);
    end else begin
      target_nxt = target_r;
    end
  end

  // Sequencer: status follows the target only after the settle time
  always_comb begin
    seq_nxt = seq_r;
    cnt_nxt = cnt_r;
    chan_state_nxt = chan_state_r;
    unique case (seq_r)
      SEQ_IDLE: begin
        if (target_r != chan_state_r) begin
          seq_nxt = SEQ_RAMP;
          cnt_nxt = CNT_ONE;
        end
      end
      SEQ_RAMP: begin
        if (cnt_r >= POWER_SETTLE_CYC) begin
          chan_state_nxt = target_r;
          seq_nxt = SEQ_IDLE;
          cnt_nxt = CNT_ZERO;
        end else begin
          cnt_nxt = cnt_r + CNT_ONE;
        end
      end
    endcase
  end

  // Mode field from real channel state
  always_comb begin
    if (sleep_in) begin
      mode_nxt = MODE_SLEEP;
    end else if (|chan_state_nxt) begin
      mode_nxt = MODE_ACTIVE_ON;
    end else begin
      mode_nxt = MODE_ACTIVE_OFF;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      target_r <= CH_NONE;
      chan_state_r <= RST_CHANNEL_POWER_STATE;
      cnt_r <= CNT_ZERO;
      seq_r <= SEQ_IDLE;
      mode_r <= RST_DEVICE_MODE_STATE[MODE_HI:MODE_LO];
    end else if (ce_in) begin
      target_r <= target_nxt;
      chan_state_r <= chan_state_nxt;
      cnt_r <= cnt_nxt;
      seq_r <= seq_nxt;
      mode_r <= mode_nxt;
    end
  end

  assign rd_data_out = rd_data_r;
  assign channel_power_out = chan_state_r;

  // Checks
  frozen_set_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && any_on && !dynamic_channel_power_enable && converter_power_control && !sleep_in
    |=> target_r == $past(target_r))
    else $error("channel set changed with dynamic control off");

  dyn_range_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && any_on && dynamic_channel_power_enable && converter_power_control && !sleep_in
    |=> (target_r & $past(dyn_mask)) == ($past(request) & $past(dyn_mask)))
    else $error("in-range channel did not follow its enable");

  outside_range_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && any_on && dynamic_channel_power_enable && converter_power_control && !sleep_in
    |=> (target_r & ~$past(dyn_mask)) == ($past(target_r) & ~$past(dyn_mask)))
    else $error("out-of-range channel changed");

  state_read_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && rd_en_in && is_main_addr(access_in, ADDR_CHANNEL_POWER_STATE)
    |=> rd_data_out == $past(chan_state_r))
    else $error("channel state read mismatch");

  mode_sleep_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && sleep_in |=> mode_r == MODE_SLEEP)
    else $error("mode not sleep");

  mode_off_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && !sleep_in && chan_state_nxt == CH_NONE |=> mode_r == MODE_ACTIVE_OFF)
    else $error("mode not active-off");

  mode_on_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && !sleep_in ##1 any_on |-> mode_r == MODE_ACTIVE_ON)
    else $error("mode not active-on");

  mode_read_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && rd_en_in && is_main_addr(access_in, ADDR_DEVICE_MODE_STATE)
    |=> rd_data_out == {$past(mode_r), MODE_RESERVED})
    else $error("reserved mode bits not zero");

  cksum_load_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && wr_en_in && is_main_addr(access_in, ADDR_CHECKSUM)
    |=> checksum_r == $past(access_in.data))
    else $error("checksum not loaded");

  cksum_update_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && wr_en_in && !is_main_addr(access_in, ADDR_CHECKSUM)
    |=> checksum_r == DATA_W'($past(checksum_r) + $past(access_in.addr) + $past(access_in.data)))
    else $error("checksum not updated");

  settle_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && seq_r == SEQ_IDLE && target_r != chan_state_r
    |=> chan_state_r == $past(chan_state_r))
    else $error("status changed before settle time");

  power_off_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && !converter_power_control |=> target_r == CH_NONE)
    else $error("channels not powered down");

  // Sequencing and read path checks
  ramp_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && seq_r == SEQ_RAMP && cnt_r < POWER_SETTLE_CYC
    |=> chan_state_r == $past(chan_state_r))
    else $error("status changed during ramp");

  settle_done_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && seq_r == SEQ_RAMP && cnt_r >= POWER_SETTLE_CYC
    |=> chan_state_r == $past(target_r) && seq_r == SEQ_IDLE)
    else $error("status did not take target after settle");

  idle_count_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    seq_r == SEQ_IDLE
    |-> cnt_r == CNT_ZERO)
    else $error("settle counter not cleared while idle");

  state_idle_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && seq_r == SEQ_IDLE
    |=> chan_state_r == $past(chan_state_r))
    else $error("channel state changed without sequencing");

  state_freeze_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !ce_in
    |=> chan_state_r == $past(chan_state_r) && mode_r == $past(mode_r))
    else $error("status moved with clock enable low");

  cksum_freeze_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !ce_in
    |=> checksum_r == $past(checksum_r) && rd_data_out == $past(rd_data_out))
    else $error("checksum or read data moved with clock enable low");

  sleep_off_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && sleep_in
    |=> target_r == CH_NONE)
    else $error("channels requested during sleep");

  enable_only_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && !sleep_in && converter_power_control && !any_on
    |=> target_r == $past(in_ch_enable_r))
    else $error("target differs from enabled channels");

  range_decode_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (dynamic_channel_range_select == 2'h1 |-> dyn_mask == RANGE_CH1_4) and
    (dynamic_channel_range_select == 2'h2 |-> dyn_mask == RANGE_CH1_6))
    else $error("range select decoded wrongly");

  cfg_read_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && rd_en_in && is_main_addr(access_in, ADDR_POWER_CONFIGURATION)
    |=> rd_data_out == $past(power_configuration_r))
    else $error("power configuration read mismatch");

  cksum_read_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && rd_en_in && is_main_addr(access_in, ADDR_CHECKSUM)
    |=> rd_data_out == $past(checksum_r))
    else $error("checksum read mismatch");

  page_other_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && rd_en_in && access_in.page != PAGE_MAIN
    |=> rd_data_out == DATA_ZERO)
    else $error("read from another page not zero");

endmodule // channel_power_status_regs

// ==== tb/test_channel_power_status_regs.sv ====
// Register-level testbench for the channel power and status register bank
`timescale 1ns/1ns
module test_channel_power_status_regs;
  import chan_pwr_pkg::*;
  logic clk_in;
  logic rst_n_in;
  logic ce_in;
  logic wr_en_in;
  logic rd_en_in;
  reg_access_t access_in;
  logic sleep_in;
  logic [DATA_W-1:0] rd_data_out;
  logic [CH_NUM-1:0] channel_power_out;
  int error_cnt;
  int num_checks;
  logic [7:0] cks;
  logic [7:0] exp_pwr;
  logic [7:0] msk [4];

  channel_power_status_regs DUT (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .wr_en_in(wr_en_in),
    .rd_en_in(rd_en_in),
    .access_in(access_in),
    .sleep_in(sleep_in),
    .rd_data_out(rd_data_out),
    .channel_power_out(channel_power_out)
  );

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic results();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    num_checks++;
    if (got !== ex) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // Expected checksum follows every write
  task automatic wr(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] dt);
    @(posedge clk_in);
    #1;
    access_in = '{page: pg, addr: ad, data: dt};
    wr_en_in = 1'b1;
    @(posedge clk_in);
    #1;
    wr_en_in = 1'b0;
    if (pg == PAGE_MAIN && ad == ADDR_CHECKSUM) begin
      cks = dt;
    end else begin
      cks = cks + ad + dt;
    end
  endtask

  task automatic rd(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] ex);
    @(posedge clk_in);
    #1;
    access_in = '{page: pg, addr: ad, data: 8'h00};
    rd_en_in = 1'b1;
    @(posedge clk_in);
    #1;
    rd_en_in = 1'b0;
    chk($sformatf("register %h:%h", pg, ad), ex, rd_data_out);
  endtask

  task automatic settle();
    repeat (POWER_SETTLE_CYC_I + 4) @(posedge clk_in);
    #1;
  endtask

  initial begin
    #200000;
    error_cnt++;
    $display("CHECK FAILED watchdog expected done seen hang");
    results();
  end

  initial begin
    error_cnt = 0;
    num_checks = 0;
    cks = 8'h00;
    rst_n_in = 1'b0;
    ce_in = 1'b1;
    wr_en_in = 1'b0;
    rd_en_in = 1'b0;
    access_in = '0;
    sleep_in = 1'b1;
    msk = '{RANGE_CH1_2, RANGE_CH1_4, RANGE_CH1_6, RANGE_CH1_8};
    repeat (6) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    rd(PAGE_MAIN, ADDR_CHANNEL_POWER_STATE, 8'h00);
    rd(PAGE_MAIN, ADDR_DEVICE_MODE_STATE, 8'h80);
    rd(PAGE_MAIN, ADDR_CHECKSUM, 8'h00);
    rd(PAGE_MAIN, ADDR_IN_CH_ENABLE, 8'hF0);
    rd(PAGE_MAIN, ADDR_POWER_CONFIGURATION, 8'h00);
    sleep_in = 1'b0;
    rd(PAGE_MAIN, ADDR_DEVICE_MODE_STATE, 8'hC0);
    // Converter on powers the enabled channels 1-4 only
    wr(PAGE_MAIN, ADDR_POWER_CONFIGURATION, 8'h40);
    settle();
    chk("channel_power_out", 8'hF0, channel_power_out);
    rd(PAGE_MAIN, ADDR_CHANNEL_POWER_STATE, 8'hF0);
    rd(PAGE_MAIN, ADDR_DEVICE_MODE_STATE, 8'hE0);
    rd(PAGE_MAIN, ADDR_CHECKSUM, cks);
    wr(PAGE_MAIN, ADDR_CHECKSUM, 8'h11);
    rd(PAGE_MAIN, ADDR_CHECKSUM, 8'h11);
    wr(8'h01, 8'h10, 8'h05);
    rd(PAGE_MAIN, ADDR_CHECKSUM, 8'h26);
    rd(8'h01, 8'h10, 8'h00);
    // Read-only status ignores writes
    wr(PAGE_MAIN, ADDR_CHANNEL_POWER_STATE, 8'h0F);
    rd(PAGE_MAIN, ADDR_CHANNEL_POWER_STATE, 8'hF0);
    rd(PAGE_MAIN, 8'h50, 8'h00);
    // Dynamic control off: channel set frozen while recording
    wr(PAGE_MAIN, ADDR_IN_CH_ENABLE, 8'hFF);
    wr(PAGE_MAIN, ADDR_IN_CH_ENABLE, 8'h0F);
    settle();
    chk("channel_power_out", 8'hF0, channel_power_out);
    // Dynamic control on, every range in turn
    exp_pwr = 8'hF0;
    for (int r = 0; r < 4; r++) begin
      wr(PAGE_MAIN, ADDR_POWER_CONFIGURATION, {4'h5, r[1:0], 2'h0});
      // With nothing on, the converter bit powers every enabled channel
      exp_pwr = (exp_pwr == 8'h00) ? 8'h0F : ((exp_pwr & ~msk[r]) | (8'h0F & msk[r]));
      settle();
      chk("channel_power_out", exp_pwr, channel_power_out);
      rd(PAGE_MAIN, ADDR_DEVICE_MODE_STATE, (exp_pwr == 8'h00) ? 8'hC0 : 8'hE0);
    end
    rd(PAGE_MAIN, ADDR_CHECKSUM, cks);
    sleep_in = 1'b1;
    settle();
    chk("channel_power_out", 8'h00, channel_power_out);
    rd(PAGE_MAIN, ADDR_DEVICE_MODE_STATE, 8'h80);
    sleep_in = 1'b0;
    wr(PAGE_MAIN, ADDR_POWER_CONFIGURATION, 8'h00);
    settle();
    rd(PAGE_MAIN, ADDR_DEVICE_MODE_STATE, 8'hC0);
    // Clock enable low: a write is not taken
    exp_pwr = cks;
    ce_in = 1'b0;
    wr(PAGE_MAIN, ADDR_CHECKSUM, 8'h5A);
    ce_in = 1'b1;
    rd(PAGE_MAIN, ADDR_CHECKSUM, exp_pwr);
    // Reset in mid-run
    rst_n_in = 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    rd(PAGE_MAIN, ADDR_CHECKSUM, 8'h00);
    rd(PAGE_MAIN, ADDR_POWER_CONFIGURATION, 8'h00);
    rd(PAGE_MAIN, ADDR_CHANNEL_POWER_STATE, 8'h00);
    rd(PAGE_MAIN, ADDR_DEVICE_MODE_STATE, 8'hC0);
    results();
  end
endmodule // test_channel_power_status_regs
